/* include/fcc_cfg.svh */
// Constants of the flash command controller: register offsets, reset values,
// command codes, unlock values and operation times.
// Assumes a 125 MHz pclk; operation times are given in microseconds, the signature time in pclk cycles.
`ifndef FCC_CFG_SVH
`define FCC_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets inside one block window (byte addresses)
// ----------------------------------------------------------------------------
`define FCC_OFF_STA    7'h00
`define FCC_OFF_MOD    7'h04
`define FCC_OFF_CON    7'h08
`define FCC_OFF_DAT    7'h0C
`define FCC_OFF_ADR    7'h10
`define FCC_OFF_SGN    7'h18
`define FCC_OFF_PRO    7'h1C
`define FCC_OFF_HID    7'h20
`define FCC_BLK_BIT    7

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define FCC_STA_DONE   0
`define FCC_STA_FAIL   1
`define FCC_STA_BUSY   2
`define FCC_STA_IRQ    3
`define FCC_STA_CLRM   4'hB
`define FCC_MOD_IEN    4
`define FCC_MOD_EWEN   3
`define FCC_PRO_RD     31
`define FCC_B1_TOPBIT  30
`define FCC_RST_MOD    8'h80
`define FCC_RST_HID    32'hFFFF_FFFF
`define FCC_RST_PRO    32'h0000_0000
`define FCC_RST_SGN    24'hFF_FFFF
`define FCC_CON_DONE   8'h07

// ----------------------------------------------------------------------------
// Command codes and unlock values
// ----------------------------------------------------------------------------
`define FCC_CMD_NULL   8'h00
`define FCC_CMD_READ   8'h01
`define FCC_CMD_WRITE  8'h02
`define FCC_CMD_EWR    8'h03
`define FCC_CMD_VERIFY 8'h04
`define FCC_CMD_PERASE 8'h05
`define FCC_CMD_MERASE 8'h06
`define FCC_CMD_SIGN   8'h0B
`define FCC_CMD_PROT   8'h0C
`define FCC_CMD_PING   8'h0F
`define FCC_ME_DAT     16'h3CFF
`define FCC_ME_ADR     16'hFFC3
`define FCC_KEY_PERM   32'hDEAD_DEAD

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define FCC_CLK_MHZ    125
`define FCC_T_WR_US    50
`define FCC_T_EW_US    20000
`define FCC_T_PE_US    20000
`define FCC_T_ME_US    2480000
`define FCC_T_PR_US    50
`define FCC_SIGN_CYC   32778
`define FCC_SIGN_WORDS 32768

`endif

/* include/fcc_pkg.sv */
// Types of the flash command controller: array request, persistent store
// interface, sequencer states and the controller state record.
// Assumes fcc_cfg.svh is on the include path.
package fcc_pkg;

   // -------------------------------------------------------------------------
   // Link types
   // -------------------------------------------------------------------------
   typedef enum logic [2:0] {FA_NONE, FA_READ, FA_PROG, FA_EPAGE, FA_EALL} fcc_fa_op_e;

   typedef struct packed {
      fcc_fa_op_e  op;     // One-cycle strobe
      logic        blk;
      logic [15:0] addr;
      logic [15:0] wdata;
   } fcc_fa_s;

   typedef struct packed {
      logic [31:0] prot;   // Saved protection word
      logic [31:0] key;    // Stored key
      logic        keyed;  // A key has been saved
   } fcc_nvm_s;

   typedef struct packed {
      logic        we;     // One-cycle strobe
      logic        clear;  // Mass erase: forget key and word
      logic        blk;
      logic [31:0] prot;
      logic [31:0] key;
   } fcc_nvw_s;

   // -------------------------------------------------------------------------
   // Controller state
   // -------------------------------------------------------------------------
   typedef enum logic [1:0] {S_IDLE, S_RDATA, S_SIGN, S_TIMED} fcc_st_e;

   typedef struct packed {
      logic [1:0][3:0]  sta;
      logic [1:0][7:0]  mod;
      logic [1:0][7:0]  con;
      logic [1:0][15:0] dat;
      logic [1:0][15:0] adr;
      logic [1:0][23:0] sgn;
      logic [1:0][31:0] pro;
      logic [1:0][31:0] hid;
      logic [1:0][31:0] boot;
      logic             booted;
      fcc_st_e          st;
      logic             blk;
      logic [7:0]       code;
      logic [15:0]      oadr;
      logic [15:0]      odat;
      logic [31:0]      timer;
      logic [15:0]      widx;
      logic             rv;
      logic [23:0]      acc;
      logic [31:0]      prdata;
      logic [1:0]       ws;
      fcc_fa_s          fa;
      fcc_nvw_s         nvw;
   } fcc_state_s;

endpackage

/* design/fcc_top.sv */
// Flash command controller for two 64 kB flash blocks, APB register slave.
// Assumes an array that takes one-cycle strobes and returns read data one
// cycle after a read strobe, and a persistent store on the same clock.
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ns
`include "fcc_cfg.svh"
`default_nettype none

module fcc_top #(
   parameter int unsigned T_WR_CYC = `FCC_T_WR_US * `FCC_CLK_MHZ,
   parameter int unsigned T_EW_CYC = `FCC_T_EW_US * `FCC_CLK_MHZ,
   parameter int unsigned T_PE_CYC = `FCC_T_PE_US * `FCC_CLK_MHZ,
   parameter int unsigned T_ME_CYC = `FCC_T_ME_US * `FCC_CLK_MHZ,
   parameter int unsigned T_PR_CYC = `FCC_T_PR_US * `FCC_CLK_MHZ,
   parameter int unsigned SIGN_CYC = `FCC_SIGN_CYC,
   parameter int unsigned SIGN_WDS = `FCC_SIGN_WORDS
) (
   input  wire logic            pclk,      // 125 MHz clock
   input  wire logic            presetn,   // Async reset, active low
   input  wire logic            psel,      // APB select
   input  wire logic            penable,   // APB access phase
   input  wire logic            pwrite,    // APB direction
   input  wire logic [11:0]     paddr,     // APB byte address
   input  wire logic [31:0]     pwdata,    // APB write data
   output logic     [31:0]      prdata,    // APB read data
   output logic                 pready,    // APB ready
   output logic                 pslverr,   // Unmapped address
   output fcc_pkg::fcc_fa_s     fa_o,      // Array request strobe
   input  wire logic [15:0]     fa_rdata,  // Array read data
   input  wire fcc_pkg::fcc_nvm_s nvm0_i,  // Block 0 persistent store
   input  wire fcc_pkg::fcc_nvm_s nvm1_i,  // Block 1 persistent store
   output fcc_pkg::fcc_nvw_s    nvw_o,     // Persistent store write
   output logic                 flash_irq, // Completion interrupt
   output logic [1:0]           wait_states // Wait states in force
);
   import fcc_pkg::*;

   fcc_state_s q;
   fcc_state_s d;
   logic       start_w;
   logic       fin_w;
   logic       fail_w;
   logic       fb_w;
   logic [7:0] cw_w;

   // -------------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------------

   // Page group of a byte address: 512-byte pages, four pages a group
   function automatic logic wr_ok(input logic b, input logic [15:0] a,
                                  input logic [31:0] p);
      logic [4:0] g;
      g = a[15:11];
      if (!b)
         wr_ok = (g == 5'd31) ? 1'b0 : p[g];
      else
         wr_ok = (g >= 5'd30) ? p[`FCC_B1_TOPBIT] : p[g];
   endfunction

   function automatic logic mapped(input logic [6:0] o);
      mapped = (o == `FCC_OFF_STA) || (o == `FCC_OFF_MOD) || (o == `FCC_OFF_CON) ||
               (o == `FCC_OFF_DAT) || (o == `FCC_OFF_ADR) || (o == `FCC_OFF_SGN) ||
               (o == `FCC_OFF_PRO) || (o == `FCC_OFF_HID);
   endfunction

   function automatic logic is_ew(input logic [7:0] c);
      is_ew = (c == `FCC_CMD_WRITE) || (c == `FCC_CMD_EWR) ||
              (c == `FCC_CMD_PERASE) || (c == `FCC_CMD_MERASE);
   endfunction

   // -------------------------------------------------------------------------
   // Bus decode
   // -------------------------------------------------------------------------
   logic       rb;
   logic [6:0] ro;
   logic       hit;
   logic       acc_w;
   logic [1:0][31:0] prot;

   // Effective protection: immediate word ANDed with word loaded at boot
   assign prot[0] = q.hid[0] & q.boot[0];
   assign prot[1] = q.hid[1] & q.boot[1];
   assign rb      = paddr[`FCC_BLK_BIT];
   assign ro      = paddr[6:0];
   assign hit     = (paddr[11:8] == 4'h0) && mapped(ro);
   assign acc_w   = psel && penable;
   assign pready  = 1'b1;
   assign pslverr = acc_w && !hit;

   // -------------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------------
   always_comb begin
      logic [7:0] c;
      logic       ok;
      logic       fin_ok;
      logic       fin_bad;
      d       = q;
      c       = pwdata[7:0];
      ok      = 1'b0;
      fin_ok  = 1'b0;
      fin_bad = 1'b0;
      start_w = 1'b0;
      fb_w    = q.blk;
      cw_w    = q.code;
      d.fa    = '0;
      d.nvw   = '0;
      d.rv    = (q.fa.op == FA_READ);  // Array data stands the cycle after a read strobe

      // Saved protection is caught once, on the first edge after reset
      if (!q.booted) begin
         d.boot[0] = nvm0_i.prot;
         d.boot[1] = nvm1_i.prot;
         d.booted  = 1'b1;
      end

      // Read data is latched in the setup cycle so prdata comes from a flop
      if (psel && !penable && !pwrite) begin
         d.prdata = '0;
         case (ro)
            `FCC_OFF_STA: d.prdata[3:0]  = q.sta[rb];
            `FCC_OFF_MOD: d.prdata[7:0]  = q.mod[rb];
            `FCC_OFF_CON: d.prdata[7:0]  = q.con[rb];
            `FCC_OFF_DAT: d.prdata[15:0] = q.dat[rb];
            `FCC_OFF_ADR: d.prdata[15:0] = q.adr[rb];
            `FCC_OFF_SGN: d.prdata[23:0] = q.sgn[rb];
            `FCC_OFF_PRO: d.prdata       = q.pro[rb];
            `FCC_OFF_HID: d.prdata       = q.hid[rb];
            default:      d.prdata       = '0;
         endcase
         if (!hit) d.prdata = '0;
      end

      // Status read clears only the bits that the reader actually saw
      if (acc_w && !pwrite && hit && ro == `FCC_OFF_STA)
         d.sta[rb] = q.sta[rb] & ~(q.prdata[3:0] & `FCC_STA_CLRM);

      // Register writes; the command register starts the sequencer
      if (acc_w && pwrite && hit) begin
         case (ro)
            `FCC_OFF_MOD: d.mod[rb] = pwdata[7:0];
            `FCC_OFF_DAT: d.dat[rb] = pwdata[15:0];
            `FCC_OFF_ADR: d.adr[rb] = pwdata[15:0];
            `FCC_OFF_PRO: d.pro[rb] = pwdata;
            `FCC_OFF_HID: d.hid[rb] = pwdata;
            `FCC_OFF_CON: start_w   = (q.st == S_IDLE);
            default: ;
         endcase
      end

      // Command issue
      if (start_w) begin
         d.blk  = rb;
         d.code = c;
         d.con[rb] = c;
         d.oadr = q.adr[rb];
         d.odat = q.dat[rb];
         fb_w   = rb;
         cw_w   = c;
         case (c)
            `FCC_CMD_NULL: d.con[rb] = `FCC_CON_DONE;
            `FCC_CMD_READ, `FCC_CMD_VERIFY: begin
               if (prot[rb][`FCC_PRO_RD]) begin
                  d.fa = '{op: FA_READ, blk: rb, addr: q.adr[rb], wdata: 16'h0000};
                  d.st = S_RDATA;
               end else fin_bad = 1'b1;
            end
            `FCC_CMD_WRITE, `FCC_CMD_EWR, `FCC_CMD_PERASE: begin
               ok = q.mod[rb][`FCC_MOD_EWEN] && wr_ok(rb, q.adr[rb], prot[rb]);
               if (ok) begin
                  d.st = S_TIMED;
                  if (c == `FCC_CMD_WRITE) begin
                     d.fa    = '{op: FA_PROG, blk: rb, addr: q.adr[rb], wdata: q.dat[rb]};
                     d.timer = 32'(T_WR_CYC - 1);
                  end else begin
                     d.fa    = '{op: FA_EPAGE, blk: rb, addr: q.adr[rb], wdata: 16'h0000};
                     d.timer = (c == `FCC_CMD_EWR) ? 32'(T_EW_CYC - 1) : 32'(T_PE_CYC - 1);
                  end
               end else fin_bad = 1'b1;
            end
            `FCC_CMD_MERASE: begin
               ok = q.mod[rb][`FCC_MOD_EWEN] && q.dat[rb] == `FCC_ME_DAT &&
                    q.adr[rb] == `FCC_ME_ADR;
               if (ok) begin
                  // The array keeps the kernel group of block 0 itself
                  d.fa    = '{op: FA_EALL, blk: rb, addr: 16'h0000, wdata: 16'h0000};
                  d.nvw   = '{we: 1'b1, clear: 1'b1, blk: rb, prot: 32'h0, key: 32'h0};
                  d.timer = 32'(T_ME_CYC - 1);
                  d.st    = S_TIMED;
               end else fin_bad = 1'b1;
            end
            `FCC_CMD_SIGN: begin
               if (prot[rb][`FCC_PRO_RD]) begin
                  d.st    = S_SIGN;
                  d.timer = 32'(SIGN_CYC - 1);
                  d.widx  = '0;
                  d.acc   = `FCC_RST_SGN;
               end else fin_bad = 1'b1;
            end
            `FCC_CMD_PROT: begin
               // Once keyed, only the matching key reopens; the permanent key never
               ok = rb ? (!nvm1_i.keyed || ({q.adr[1], q.dat[1]} == nvm1_i.key &&
                         nvm1_i.key != `FCC_KEY_PERM))
                       : (!nvm0_i.keyed || ({q.adr[0], q.dat[0]} == nvm0_i.key &&
                         nvm0_i.key != `FCC_KEY_PERM));
               if (ok) begin
                  d.nvw   = '{we: 1'b1, clear: 1'b0, blk: rb, prot: q.pro[rb],
                              key: {q.adr[rb], q.dat[rb]}};
                  d.timer = 32'(T_PR_CYC - 1);
                  d.st    = S_TIMED;
               end else fin_bad = 1'b1;
            end
            `FCC_CMD_PING: fin_ok = 1'b1;
            default:       fin_bad = 1'b1;
         endcase
      end

      // Sequencer
      case (q.st)
         S_IDLE: ;
         S_RDATA: begin
            // Wait out the strobe cycle; sampling then would catch stale array data
            if (q.rv) begin
               d.st = S_IDLE;
               if (q.code == `FCC_CMD_READ) begin
                  d.dat[q.blk] = fa_rdata;
                  fin_ok = 1'b1;
               end else if (fa_rdata == q.odat) fin_ok = 1'b1;
               else fin_bad = 1'b1;
            end
         end
         S_SIGN: begin
            // Word read strobes run back to back; each word folds in the cycle after its strobe
            if (q.widx < 16'(SIGN_WDS) && q.timer != 32'h0) begin
               d.fa   = '{op: FA_READ, blk: q.blk, addr: {q.widx[14:0], 1'b0}, wdata: 16'h0000};
               d.widx = q.widx + 16'h0001;
            end
            if (q.rv) d.acc = {q.acc[22:0], q.acc[23]} ^ {8'h00, fa_rdata};
            d.timer = q.timer - 32'h1;
            if (q.timer == 32'h0) begin
               d.st = S_IDLE;
               d.sgn[q.blk] = q.acc;
               fin_ok = 1'b1;
            end
         end
         S_TIMED: begin
            d.timer = q.timer - 32'h1;
            if (q.timer == 32'h0) begin
               d.st = S_IDLE;
               if (q.code == `FCC_CMD_EWR)
                  d.fa = '{op: FA_PROG, blk: q.blk, addr: q.oadr, wdata: q.odat};
               fin_ok = 1'b1;
            end
         end
         default: d.st = S_IDLE;
      endcase

      // Completion: sets win over a status read in the same cycle
      fin_w  = fin_ok || fin_bad;
      fail_w = fin_bad;
      if (fin_w) begin
         d.sta[fb_w][`FCC_STA_DONE] = d.sta[fb_w][`FCC_STA_DONE] | fin_ok;
         d.sta[fb_w][`FCC_STA_FAIL] = d.sta[fb_w][`FCC_STA_FAIL] | fin_bad;
         if (q.mod[fb_w][`FCC_MOD_IEN])
            d.sta[fb_w][`FCC_STA_IRQ] = 1'b1;
         if (cw_w <= `FCC_CMD_MERASE) d.con[fb_w] = `FCC_CON_DONE;
      end

      // Busy follows the sequencer, owned by the block that issued
      d.sta[0][`FCC_STA_BUSY] = (d.st != S_IDLE) && !d.blk;
      d.sta[1][`FCC_STA_BUSY] = (d.st != S_IDLE) && d.blk;

      // Wait states move only when both blocks hold the same value
      if (q.mod[0][1:0] == q.mod[1][1:0]) d.ws = q.mod[0][1:0];
   end

   // -------------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q        <= '0;
         q.mod    <= {`FCC_RST_MOD, `FCC_RST_MOD};
         q.hid    <= {`FCC_RST_HID, `FCC_RST_HID};
         q.pro    <= {`FCC_RST_PRO, `FCC_RST_PRO};
         q.sgn    <= {`FCC_RST_SGN, `FCC_RST_SGN};
         q.boot   <= {`FCC_RST_HID, `FCC_RST_HID};
         q.st     <= S_IDLE;
      end else begin
         q <= d;
      end
   end

   assign prdata      = q.prdata;
   assign fa_o        = q.fa;
   assign nvw_o       = q.nvw;
   assign flash_irq   = q.sta[0][`FCC_STA_IRQ] | q.sta[1][`FCC_STA_IRQ];
   assign wait_states = q.ws;

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   busy_track_a: assert property (q.st != S_IDLE |-> q.sta[q.blk][2])
      else $error("busy bit low while executing");
   busy_drop_a: assert property (q.st == S_IDLE |-> !q.sta[0][2] && !q.sta[1][2])
      else $error("busy bit high while idle");
   done_set_a: assert property (fin_w && !fail_w |=> q.sta[$past(fb_w)][0])
      else $error("complete bit not set");
   fail_set_a: assert property (fin_w && fail_w |=> q.sta[$past(fb_w)][1] && !$past(fin_w && !fail_w))
      else $error("fail bit not set");
   irq_rise_a: assert property ($rose(flash_irq) |-> $past(fin_w && q.mod[fb_w][4]))
      else $error("interrupt without enabled completion");
   irq_set_a: assert property (fin_w && q.mod[fb_w][4] |=> flash_irq)
      else $error("interrupt flag not raised");
   read_clear_a: assert property (acc_w && !pwrite && hit && ro == `FCC_OFF_STA && q.prdata[0]
                                  && !(fin_w && fb_w == rb) |=> !q.sta[$past(rb)][0])
      else $error("status read did not clear");
   guard_ew_a: assert property (start_w && is_ew(cw_w) && !q.mod[rb][3]
                                |=> q.fa.op == FA_NONE && q.st == S_IDLE)
      else $error("erase or write ran while guarded");
   con_seven_a: assert property (fin_w && cw_w <= 8'h06 |=> q.con[$past(fb_w)] == 8'h07)
      else $error("command register not 0x07");
   wr_time_a: assert property (start_w && cw_w == `FCC_CMD_WRITE && q.fa.op == FA_NONE
                               ##1 q.st == S_TIMED |-> q.timer == 32'(T_WR_CYC - 1))
      else $error("write timer wrong");
   resv_idle_a: assert property (start_w && (cw_w inside {[8'h07:8'h0A], 8'h0D, 8'h0E} || cw_w > 8'h0F)
                                 |=> q.fa.op == FA_NONE && q.nvw.we == 1'b0 && q.st == S_IDLE)
      else $error("reserved code started an operation");
   sign_load_a: assert property (q.st == S_SIGN && q.timer == 32'h0
                                 |=> q.sgn[$past(q.blk)] == $past(q.acc) && q.sta[$past(q.blk)][0])
      else $error("signature not stored");

endmodule

`default_nettype wire

/* verification/fcc_top_bench.sv */
// Bench of the flash command controller: APB master tasks, an array stand-in, one task a scenario.
// Assumes fcc_pkg is compiled first and fcc_cfg.svh is on the include path.
`timescale 1ns/1ns
`include "fcc_cfg.svh"
`default_nettype none

module fcc_top_bench;
   import fcc_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, flash_irq, err_seen;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [15:0] fa_rdata = '0;
   logic [1:0]  wait_states;
   fcc_fa_s     fa_o;
   fcc_nvw_s    nvw_o;
   fcc_nvm_s    nvm0 = {32'hFFFF_FFFF, 33'h0}, nvm1 = {32'hFFFF_FFFF, 33'h0};
   int          fail_count = 0, cmp_count = 0, prog_n = 0, read_n = 0, eall_n = 0, nvw_n = 0, n0;

   // ---------------------------------------------------------------
   // Clock, design and array stand-in
   // ---------------------------------------------------------------
   always #4 pclk = ~pclk;
   fcc_top #(.T_WR_CYC(8), .T_EW_CYC(20), .T_PE_CYC(20), .T_ME_CYC(30), .T_PR_CYC(8))
   i_fcc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fa_o(fa_o), .fa_rdata(fa_rdata),
      .nvm0_i(nvm0), .nvm1_i(nvm1), .nvw_o(nvw_o), .flash_irq(flash_irq), .wait_states(wait_states));
   // Read data the cycle after a read strobe; otherwise churn so stale data never matches
   always @(posedge pclk) begin
      if (fa_o.op == FA_READ) begin
         fa_rdata <= fa_o.addr ^ 16'h5A5A;
      end else begin
         fa_rdata <= ~fa_rdata;
      end
      prog_n <= prog_n + int'(fa_o.op == FA_PROG);
      read_n <= read_n + int'(fa_o.op == FA_READ);
      eall_n <= eall_n + int'(fa_o.op == FA_EALL);
      // Persistent store keeps the saved protection word; a mass erase opens it again
      if (nvw_o.we && nvw_o.blk) nvm1.prot <= nvw_o.clear ? 32'hFFFF_FFFF : nvw_o.prot;
      if (nvw_o.we && !nvw_o.blk) nvm0.prot <= nvw_o.clear ? 32'hFFFF_FFFF : nvw_o.prot;
      nvw_n <= nvw_n + int'(nvw_o.we);
   end

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   function automatic logic [11:0] ra(input logic b, input logic [6:0] o);
      return {4'h0, b, o};
   endfunction
   task automatic results();
      $display("compares %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic fail_out();
      fail_count++;
      results();
   endtask
   // One APB transfer; request held until pready is seen high with penable
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 20) fail_out();
      rd = prdata;
      err_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask
   // Start a command, wait for the completion interrupt, check the status word
   task automatic do_cmd(input logic b, input logic [7:0] c, input logic [31:0] exp);
      int n;
      apb(1'b1, ra(b, `FCC_OFF_CON), {24'h0, c});
      for (n = 0; n < 40000 && flash_irq !== 1'b1; n++) @(posedge pclk);
      if (n == 40000) fail_out();
      rdc(ra(b, `FCC_OFF_STA), exp);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      rdc(ra(0, `FCC_OFF_MOD), 32'h0000_0080);
      rdc(ra(1, `FCC_OFF_HID), 32'hFFFF_FFFF);
      rdc(ra(0, `FCC_OFF_PRO), 32'h0000_0000);
      rdc(ra(0, `FCC_OFF_SGN), 32'h00FF_FFFF);
      rdc(ra(0, `FCC_OFF_STA), 32'h0000_0000);
      rdc(12'h014, 32'h0000_0000);
      chk(err_seen, 1'b1);
   endtask
   task automatic t_read();
      apb(1'b1, ra(0, `FCC_OFF_MOD), 32'h0000_0018);
      apb(1'b1, ra(0, `FCC_OFF_ADR), 32'h0000_0010);
      do_cmd(0, `FCC_CMD_READ, 32'h0000_0009);
      rdc(ra(0, `FCC_OFF_DAT), 32'h0000_5A4A);
      rdc(ra(0, `FCC_OFF_CON), 32'h0000_0007);
      rdc(ra(0, `FCC_OFF_STA), 32'h0000_0000);
      chk(flash_irq, 1'b0);
   endtask
   // Write, erase-write and page erase codes refused while the guard bit is clear
   task automatic t_guard();
      logic [7:0] cs [3] = '{`FCC_CMD_WRITE, `FCC_CMD_EWR, `FCC_CMD_PERASE};
      apb(1'b1, ra(0, `FCC_OFF_MOD), 32'h0000_0010);
      n0 = prog_n;
      foreach (cs[i]) do_cmd(0, cs[i], 32'h0000_000A);
      chk(prog_n, n0);
      apb(1'b1, ra(0, `FCC_OFF_MOD), 32'h0000_0018);
   endtask
   task automatic t_write();
      int n;
      n0 = prog_n;
      apb(1'b1, ra(0, `FCC_OFF_DAT), 32'h0000_1234);
      apb(1'b1, ra(0, `FCC_OFF_CON), {24'h0, `FCC_CMD_WRITE});
      rdc(ra(0, `FCC_OFF_STA), 32'h0000_0004);
      for (n = 0; n < 300 && flash_irq !== 1'b1; n++) @(posedge pclk);
      if (n == 300) fail_out();
      rdc(ra(0, `FCC_OFF_STA), 32'h0000_0009);
      do_cmd(0, `FCC_CMD_EWR, 32'h0000_0009);
      chk(prog_n, n0 + 2);
      do_cmd(0, `FCC_CMD_PERASE, 32'h0000_0009);
      chk(prog_n, n0 + 2);
   endtask
   task automatic t_verify();
      do_cmd(0, `FCC_CMD_VERIFY, 32'h0000_000A);
      apb(1'b1, ra(0, `FCC_OFF_DAT), 32'h0000_5A4A);
      do_cmd(0, `FCC_CMD_VERIFY, 32'h0000_0009);
   endtask
   // Reserved codes fail and touch nothing
   task automatic t_rsv();
      logic [7:0] cs [6] = '{8'h07, 8'h08, 8'h09, 8'h0A, 8'h0D, 8'h0E};
      apb(1'b1, ra(1, `FCC_OFF_MOD), 32'h0000_0010);
      n0 = prog_n + eall_n;
      foreach (cs[i]) do_cmd(1, cs[i], 32'h0000_000A);
      chk(prog_n + eall_n, n0);
   endtask
   task automatic t_sign_erase();
      n0 = read_n;
      do_cmd(0, `FCC_CMD_SIGN, 32'h0000_0009);
      chk(read_n - n0, `FCC_SIGN_WORDS);
      do_cmd(0, `FCC_CMD_MERASE, 32'h0000_000A);
      apb(1'b1, ra(0, `FCC_OFF_DAT), {16'h0, `FCC_ME_DAT});
      apb(1'b1, ra(0, `FCC_OFF_ADR), {16'h0, `FCC_ME_ADR});
      do_cmd(0, `FCC_CMD_MERASE, 32'h0000_0009);
      chk(eall_n, 1);
      chk(nvw_n, 1);
   endtask
   // Ping with the interrupt enable clear: done only, no interrupt
   task automatic t_ping();
      apb(1'b1, ra(0, `FCC_OFF_MOD), 32'h0000_0008);
      apb(1'b1, ra(0, `FCC_OFF_CON), {24'h0, `FCC_CMD_PING});
      repeat (3) @(posedge pclk);
      chk(flash_irq, 1'b0);
      rdc(ra(0, `FCC_OFF_STA), 32'h0000_0001);
   endtask
   task automatic t_prot();
      apb(1'b1, ra(1, `FCC_OFF_MOD), 32'h0000_0018);
      apb(1'b1, ra(1, `FCC_OFF_HID), 32'h7FFF_FFFF);
      do_cmd(1, `FCC_CMD_READ, 32'h0000_000A);
      apb(1'b1, ra(0, `FCC_OFF_MOD), 32'h0000_0018);
      apb(1'b1, ra(0, `FCC_OFF_ADR), 32'h0000_0010);
      apb(1'b1, ra(0, `FCC_OFF_HID), 32'hFFFF_FFFE);
      do_cmd(0, `FCC_CMD_WRITE, 32'h0000_000A);
      apb(1'b1, ra(0, `FCC_OFF_HID), 32'h7FFF_FFFF);
      do_cmd(0, `FCC_CMD_READ, 32'h0000_000A);
      apb(1'b1, ra(0, `FCC_OFF_PRO), 32'h7FFF_FFFF);
      do_cmd(0, `FCC_CMD_PROT, 32'h0000_0009);
      chk(nvw_n, 2);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdc(ra(0, `FCC_OFF_HID), 32'hFFFF_FFFF);
      apb(1'b1, ra(0, `FCC_OFF_MOD), 32'h0000_0018);
      do_cmd(0, `FCC_CMD_READ, 32'h0000_000A);
   endtask
   task automatic t_ws();
      apb(1'b1, ra(0, `FCC_OFF_MOD), 32'h0000_0002);
      repeat (3) @(posedge pclk);
      chk(wait_states, 2'd0);
      apb(1'b1, ra(1, `FCC_OFF_MOD), 32'h0000_0002);
      repeat (3) @(posedge pclk);
      chk(wait_states, 2'd2);
   endtask

   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_read();
      t_guard();
      t_write();
      t_verify();
      t_rsv();
      t_sign_erase();
      t_ping();
      t_prot();
      t_ws();
      results();
   end
endmodule
`default_nettype wire
